// ---- hdl/data_regs.sv ----
`timescale 1ns/10ps
// Function
// R01 - data memory is one file of special-function and general byte registers
// R02 - small variant: seven special-function and sixteen general bytes
// R03 - large variant: eight special-function and twenty-four general bytes
// R04 - general bytes reachable by direct address and through indirect_pointer
// R05 - special-function map 00h..07h; address 00h forwards to indirect_pointer target
// R06 - pc_low_byte shows only low pc byte, resets to all ones
// R07 - without comparator, status bit 6 is reserved
// R08 - power-on values only at power-up; other resets load their own values
// R09 - port_direction and timer_option_control have no data address
// R10 - writes to timeout_flag and power_down_flag are ignored
// R11 - flag-updating instruction to status: flags come from result, not data
// R12 - without comparator, 07h reads zero and ignores writes
module data_regs #(
  parameter bit LARGE_FILE = 1'b1,
  parameter bit HAS_CMP = 1'b1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic other_rst,
  input wire logic wake_cause,
  input wire logic [data_regs_pkg::ADDR_W-1:0] addr,
  input wire logic [data_regs_pkg::DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [data_regs_pkg::DATA_W-1:0] rd_data,
  input wire logic alu_flags_upd,
  input wire logic [2:0] alu_flags,
  input wire logic hw_flag_load,
  input wire logic hw_timeout,
  input wire logic hw_power_down,
  input wire logic pc_load,
  input wire logic [data_regs_pkg::DATA_W-1:0] pc_value,
  output logic [data_regs_pkg::DATA_W-1:0] pc_low,
  output logic [data_regs_pkg::DATA_W-1:0] status,
  input wire logic timer_tick,
  input wire logic cmp_wake,
  input wire logic dir_load,
  input wire logic [data_regs_pkg::PIN_W-1:0] dir_value,
  input wire logic option_load,
  input wire logic [data_regs_pkg::DATA_W-1:0] option_value,
  output logic [data_regs_pkg::DATA_W-1:0] option,
  output logic [data_regs_pkg::DATA_W-1:0] osc_cal,
  output logic [data_regs_pkg::DATA_W-1:0] cmp_control,
  input wire logic [data_regs_pkg::PIN_W-1:0] pins_in,
  output logic [data_regs_pkg::PIN_W-1:0] port_out,
  output logic [data_regs_pkg::PIN_W-1:0] port_oe,
  output logic irq
);
  import data_regs_pkg::*;

  // first general byte address depends on the variant
  localparam logic [FADDR_W-1:0] GPR_LO = LARGE_FILE ? F_GPR_LO_LARGE : F_GPR_LO_SMALL; // R02 R03

  logic [DATA_W-1:0] timer_q;
  logic [DATA_W-1:0] timer_d;
  logic [FADDR_W-1:0] ptr_q;
  logic [PIN_W-1:0] port_latch_q;
  logic [PIN_W-1:0] pins_prev_q;
  logic [1:0] pin_arm_q;
  logic [EVT_W-1:0] evt_q;
  logic [EVT_W-1:0] evt_d;
  logic [EVT_W-1:0] mask_q;
  logic [DATA_W-1:0] status_d;
  logic [PIN_W-1:0] pins_s;
  logic [DATA_W-1:0] gpr_rd;

  //////////////////////////////////////////////////////////////////////////////
  // address decode; indirect slot resolves to the pointer before decoding
  wire is_mem = addr <= A_MEM_TOP;
  wire [FADDR_W-1:0] direct_fa = addr[FADDR_W-1:0];
  wire is_ind = is_mem && direct_fa == F_INDIRECT; // R05
  wire [FADDR_W-1:0] eff_fa = is_ind ? ptr_q : direct_fa; // R04
  // pointer aimed at itself hits nothing: reads zero, writes dropped
  wire sel_tmr = is_mem && eff_fa == F_TIMER; // R05
  wire sel_pc = is_mem && eff_fa == F_PC_LOW;
  wire sel_st = is_mem && eff_fa == F_STATUS;
  wire sel_ptr = is_mem && eff_fa == F_POINTER;
  wire sel_osc = is_mem && eff_fa == F_OSC_CAL;
  wire sel_port = is_mem && eff_fa == F_PORT;
  wire sel_cmp = HAS_CMP && is_mem && eff_fa == F_CMP_CTRL; // R12
  wire sel_gpr = is_mem && eff_fa >= GPR_LO && eff_fa <= F_GPR_HI; // R01 R04
  wire sel_evt = addr == A_EVT_STATUS;
  wire sel_mask = addr == A_EVT_MASK;
  wire [GPR_IDX_W-1:0] gpr_idx = GPR_IDX_W'(eff_fa - F_GPR_LO_LARGE);

  // write strobes per register
  wire wr_tmr = wr_en && sel_tmr;
  wire wr_pc = wr_en && sel_pc;
  wire wr_st = wr_en && sel_st;
  wire wr_ptr = wr_en && sel_ptr;
  wire wr_osc = wr_en && sel_osc;
  wire wr_port = wr_en && sel_port;
  wire wr_cmp = wr_en && sel_cmp; // R12
  wire wr_gpr = wr_en && sel_gpr;
  wire wr_mask = wr_en && sel_mask;
  wire rd_evt = rd_en && sel_evt;

  //////////////////////////////////////////////////////////////////////////////
  // read data selection; unmapped addresses give zero
  wire [DATA_W-1:0] ptr_view = {POINTER_HIGH, ptr_q};
  wire [DATA_W-1:0] port_view = {{(DATA_W-PIN_W){1'b0}}, pins_s};
  wire [DATA_W-1:0] evt_view = {{(DATA_W-EVT_W){1'b0}}, evt_q};
  wire [DATA_W-1:0] mask_view = {{(DATA_W-EVT_W){1'b0}}, mask_q};
  wire [DATA_W-1:0] rd_mux =
      ({DATA_W{sel_tmr}} & timer_q) |
      ({DATA_W{sel_pc}} & pc_low) | // R06
      ({DATA_W{sel_st}} & status) |
      ({DATA_W{sel_ptr}} & ptr_view) |
      ({DATA_W{sel_osc}} & osc_cal) |
      ({DATA_W{sel_port}} & port_view) |
      ({DATA_W{sel_cmp}} & cmp_control) | // R12
      ({DATA_W{sel_gpr}} & gpr_rd) |
      ({DATA_W{sel_evt}} & evt_view) |
      ({DATA_W{sel_mask}} & mask_view);

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_data <= '0;
    end else begin
      rd_data <= rd_en ? rd_mux : '0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // general purpose bytes
  gpr_store u_gpr (
    .clk_sys(clk_sys),
    .wr_en(wr_gpr),
    .idx(gpr_idx),
    .wr_data(wr_data),
    .rd_data(gpr_rd)
  );

  // port pins pass two flops before anything reads them
  pin_sync u_sync (
    .clk_sys(clk_sys),
    .pins_async(pins_in),
    .pins_sync(pins_s)
  );

  //////////////////////////////////////////////////////////////////////////////
  // timer count: a software write wins over a tick in the same cycle
  wire tmr_wrap = timer_tick && !wr_tmr && timer_q == '1;
  assign timer_d = wr_tmr ? wr_data : (timer_tick ? timer_q + 1'b1 : timer_q);

  // power-on value is undefined; zero chosen, other resets keep it
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      timer_q <= '0;
    end else begin
      timer_q <= timer_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // program counter low byte; core load and software write share it
  always_ff @(posedge clk_sys) begin
    if (rst || other_rst) begin
      pc_low <= PC_LOW_RST; // R06 R08
    end else if (wr_pc) begin
      pc_low <= wr_data;
    end else if (pc_load) begin
      pc_low <= pc_value;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // core_status next value
  always_comb begin
    status_d = status;
    if (hw_flag_load) begin
      status_d[ST_TIMEOUT] = hw_timeout;
      status_d[ST_POWER_DOWN] = hw_power_down;
    end
    if (wr_st) begin
      // timeout and power-down bits are never taken from the data
      status_d[ST_PIN_WAKE] = wr_data[ST_PIN_WAKE]; // R10
      status_d[ST_CMP_WAKE] = HAS_CMP && wr_data[ST_CMP_WAKE]; // R07
      if (!alu_flags_upd) begin
        status_d[ST_NULL] = wr_data[ST_NULL];
        status_d[ST_NIBBLE] = wr_data[ST_NIBBLE];
        status_d[ST_CARRY] = wr_data[ST_CARRY];
      end
    end
    // the instruction result overrides the data write on these flags
    if (alu_flags_upd) begin
      status_d[ST_NULL] = alu_flags[2]; // R11
      status_d[ST_NIBBLE] = alu_flags[1]; // R11
      status_d[ST_CARRY] = alu_flags[0]; // R11
    end
    // hardware wake flag sets win over a software clear
    if (HAS_CMP && cmp_wake) begin
      status_d[ST_CMP_WAKE] = 1'b1;
    end
    if (other_rst) begin
      status_d[ST_PIN_WAKE] = wake_cause; // R08
      status_d[ST_CMP_WAKE] = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status <= STATUS_POR; // R08
    end else begin
      status <= status_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // indirect pointer; upper three bits read as ones
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ptr_q <= '0;
    end else if (wr_ptr) begin
      ptr_q <= wr_data[FADDR_W-1:0]; // R04
    end
  end

  // calibration keeps its value over non power-up resets
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      osc_cal <= OSC_CAL_RST; // R08
    end else if (wr_osc) begin
      osc_cal <= wr_data;
    end
  end

  // comparator control only exists on the comparator variant
  always_ff @(posedge clk_sys) begin
    if (rst || other_rst || !HAS_CMP) begin
      cmp_control <= HAS_CMP ? CMP_CTRL_RST : '0; // R12
    end else if (wr_cmp) begin
      cmp_control <= wr_data;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // direction and option load through their own strobes, not the file
  always_ff @(posedge clk_sys) begin
    if (rst || other_rst) begin
      option <= OPTION_RST; // R09 R08
    end else if (option_load) begin
      option <= option_value; // R09
    end
  end

  // enable is the inverse of direction; the input-only pin never drives
  always_ff @(posedge clk_sys) begin
    if (rst || other_rst) begin
      port_oe <= ~PORT_DIR_RST; // R09
    end else if (dir_load) begin
      port_oe <= ~dir_value; // R09
      port_oe[PIN_INPUT_ONLY] <= 1'b0;
    end
  end

  // output latch; reads show the pins, not the latch
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      port_latch_q <= '0;
      port_out <= '0;
    end else begin
      if (wr_port) begin
        port_latch_q <= wr_data[PIN_W-1:0];
      end
      port_out <= wr_port ? wr_data[PIN_W-1:0] : port_latch_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin change: armed after the synchroniser has filled after reset
  wire pin_armed = pin_arm_q == PIN_ARM_DONE;
  wire pin_change = pin_armed && (pins_s != pins_prev_q);

  always_ff @(posedge clk_sys) begin
    pins_prev_q <= pins_s;
    if (rst) begin
      pin_arm_q <= '0;
    end else if (!pin_armed) begin
      pin_arm_q <= pin_arm_q + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sticky events, cleared by reading; a same-cycle event still lands
  wire [EVT_W-1:0] evt_set = {other_rst && wake_cause, HAS_CMP && cmp_wake, pin_change, tmr_wrap};
  assign evt_d = (evt_q & ~{EVT_W{rd_evt}}) | evt_set;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      evt_q <= '0;
      mask_q <= '0;
      irq <= 1'b0;
    end else begin
      evt_q <= evt_d;
      if (wr_mask) begin
        mask_q <= wr_data[EVT_W-1:0];
      end
      irq <= |(evt_d & (wr_mask ? wr_data[EVT_W-1:0] : mask_q));
    end
  end

endmodule // data_regs

// ---- hdl/data_regs_pkg.sv ----
package data_regs_pkg;

  // bus and datapath widths
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int PIN_W = 4;
  localparam int FADDR_W = 5;
  localparam int GPR_DEPTH = 24;
  localparam int GPR_IDX_W = 5;
  localparam int EVT_W = 4;

  //////////////////////////////////////////////////////////////////////////////
  // data memory file addresses
  localparam logic [FADDR_W-1:0] F_INDIRECT = 5'h00;
  localparam logic [FADDR_W-1:0] F_TIMER = 5'h01;
  localparam logic [FADDR_W-1:0] F_PC_LOW = 5'h02;
  localparam logic [FADDR_W-1:0] F_STATUS = 5'h03;
  localparam logic [FADDR_W-1:0] F_POINTER = 5'h04;
  localparam logic [FADDR_W-1:0] F_OSC_CAL = 5'h05;
  localparam logic [FADDR_W-1:0] F_PORT = 5'h06;
  localparam logic [FADDR_W-1:0] F_CMP_CTRL = 5'h07;
  localparam logic [FADDR_W-1:0] F_GPR_LO_LARGE = 5'h08;
  localparam logic [FADDR_W-1:0] F_GPR_LO_SMALL = 5'h10;
  localparam logic [FADDR_W-1:0] F_GPR_HI = 5'h1f;

  // bus-only registers above the data memory file
  localparam logic [ADDR_W-1:0] A_MEM_TOP = 6'h1f;
  localparam logic [ADDR_W-1:0] A_EVT_STATUS = 6'h20;
  localparam logic [ADDR_W-1:0] A_EVT_MASK = 6'h21;

  //////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [DATA_W-1:0] PC_LOW_RST = 8'hff;
  localparam logic [DATA_W-1:0] OSC_CAL_RST = 8'hfe;
  localparam logic [DATA_W-1:0] CMP_CTRL_RST = 8'hff;
  localparam logic [DATA_W-1:0] OPTION_RST = 8'hff;
  localparam logic [PIN_W-1:0] PORT_DIR_RST = 4'hf;
  localparam logic [DATA_W-1:0] STATUS_POR = 8'h18;
  localparam logic [2:0] POINTER_HIGH = 3'h7;
  localparam logic [1:0] PIN_ARM_DONE = 2'h3;

  // core_status bit positions
  localparam int ST_PIN_WAKE = 7;
  localparam int ST_CMP_WAKE = 6;
  localparam int ST_TIMEOUT = 4;
  localparam int ST_POWER_DOWN = 3;
  localparam int ST_NULL = 2;
  localparam int ST_NIBBLE = 1;
  localparam int ST_CARRY = 0;

  // event status / mask bit positions
  localparam int EV_TIMER_WRAP = 0;
  localparam int EV_PIN_CHANGE = 1;
  localparam int EV_CMP_WAKE = 2;
  localparam int EV_WAKE_RESET = 3;

  // the input-only pin of the port never drives
  localparam int PIN_INPUT_ONLY = 3;

endpackage

// ---- hdl/pin_sync.sv ----
`timescale 1ns/10ps
// two-stage synchroniser for the asynchronous port pins
module pin_sync (
  input wire logic clk_sys,
  input wire logic [data_regs_pkg::PIN_W-1:0] pins_async,
  output logic [data_regs_pkg::PIN_W-1:0] pins_sync
);
  import data_regs_pkg::*;

  logic [PIN_W-1:0] meta_q;

  //////////////////////////////////////////////////////////////////////////////
  // one chain per pin; the first stage feeds only the second
  for (genvar i = 0; i < PIN_W; i++) begin : g_pin
    always_ff @(posedge clk_sys) begin
      meta_q[i] <= pins_async[i];
      pins_sync[i] <= meta_q[i];
    end
  end

endmodule // pin_sync

// ---- hdl/gpr_store.sv ----
`timescale 1ns/10ps
// general purpose byte storage; contents are undefined after power-up
module gpr_store (
  input wire logic clk_sys,
  input wire logic wr_en,
  input wire logic [data_regs_pkg::GPR_IDX_W-1:0] idx,
  input wire logic [data_regs_pkg::DATA_W-1:0] wr_data,
  output logic [data_regs_pkg::DATA_W-1:0] rd_data
);
  import data_regs_pkg::*;

  logic [DATA_W-1:0] mem [GPR_DEPTH];

  //////////////////////////////////////////////////////////////////////////////
  // asynchronous read so the bus can register it next cycle
  assign rd_data = mem[idx];

  // no reset: ram content survives every reset kind
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[idx] <= wr_data;
    end
  end

endmodule // gpr_store

// ---- test/data_regs_asserts.sv ----
`timescale 1ns/10ps
// port-level watch on reset loading, hardware-owned status bits and read timing
module data_regs_asserts #(
  parameter bit HAS_CMP = 1'b1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic other_rst,
  input wire logic wake_cause,
  input wire logic [5:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rd_data,
  input wire logic alu_flags_upd,
  input wire logic [2:0] alu_flags,
  input wire logic hw_flag_load,
  input wire logic pc_load,
  input wire logic [7:0] pc_value,
  input wire logic [7:0] pc_low,
  input wire logic [7:0] status,
  input wire logic [7:0] option,
  input wire logic [7:0] osc_cal,
  input wire logic [7:0] cmp_control,
  input wire logic [3:0] port_oe
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // read data is only allowed in the cycle after a read strobe
  chk_rd_idle: assert property (!$past(rd_en) |-> rd_data == 8'h00)
    else $error("read data not idle");
  chk_rd_status: assert property (rd_en && addr == 6'h03 |=> rd_data == $past(status))
    else $error("status read wrong");
  chk_rd_pointer: assert property (rd_en && addr == 6'h04 |=> rd_data[7:5] == 3'h7)
    else $error("pointer high bits wrong");
  chk_por_values: assert property ($past(rst) |-> pc_low == 8'hff && status == 8'h18 &&
    option == 8'hff && osc_cal == 8'hfe) else $error("power-on value wrong");
  chk_other_rst: assert property (other_rst |=> pc_low == 8'hff && option == 8'hff &&
    port_oe == 4'h0 && status[7] == $past(wake_cause) && !status[6])
    else $error("other reset value wrong");
  chk_pc_load: assert property (pc_load && !wr_en && !other_rst |=> pc_low == $past(pc_value))
    else $error("pc low not loaded");
  // hardware flags must survive a software write
  chk_flags_ro: assert property (wr_en && addr == 6'h03 && !hw_flag_load && !other_rst
    |=> status[4:3] == $past(status[4:3])) else $error("timeout or power-down written");
  chk_alu_flags: assert property (wr_en && addr == 6'h03 && alu_flags_upd && !other_rst
    |=> status[2:0] == $past(alu_flags)) else $error("flags taken from data");
  chk_cmp_write: assert property (wr_en && addr == 6'h07 && !other_rst
    |=> cmp_control == (HAS_CMP ? $past(wr_data) : 8'h00)) else $error("comparator control wrong");
  chk_input_pin: assert property (port_oe[3] == 1'b0)
    else $error("input-only pin driven");
endmodule // data_regs_asserts

bind data_regs data_regs_asserts #(.HAS_CMP(HAS_CMP)) i_chk (.*);

// ---- test/core_model.sv ----
`timescale 1ns/10ps
// stands in for the core datapath: operand reads and destination writes
module core_model (
  input wire logic clk_sys,
  input wire logic [7:0] rd_data,
  input wire logic [7:0] rd_aux,
  output logic [5:0] addr,
  output logic [7:0] wr_data,
  output logic wr_en,
  output logic rd_en
);
  // bus idles with both strobes low
  initial begin
    addr = 6'h00;
    wr_data = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end

  // one-cycle write; data is scrambled after so a late sample shows up
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
    wr_data <= ~d;
  endtask

  // one-cycle read; the answer is taken only in the following cycle
  task automatic rd(input logic [5:0] a, output logic [7:0] d, output logic [7:0] d2);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    @(posedge clk_sys);
    d = rd_data;
    d2 = rd_aux;
  endtask
endmodule // core_model

// ---- test/data_regs_tb.sv ----
`timescale 1ns/10ps
// large-with-comparator and small-without variants share one bus; a file model predicts both
module data_regs_tb;
  import data_regs_pkg::*;
  logic clk_sys, rst, other_rst, wake_cause, alu_flags_upd, hw_flag_load, hw_timeout;
  logic hw_power_down, pc_load, timer_tick, cmp_wake, dir_load, option_load;
  logic wr_en, rd_en, irq;
  logic [2:0] alu_flags;
  logic [3:0] dir_value, pins_in, port_out, port_oe;
  logic [5:0] addr;
  logic [7:0] wr_data, rd_data, rd_small, pc_value, pc_low, status, option_value, option;
  logic [7:0] osc_cal, cmp_control;
  logic [31:0] seed = 32'h30b90742;
  int m[64];
  int fail_count = 0;
  int tests_run = 0;

  data_regs i_data_regs (.*);
  data_regs #(.LARGE_FILE(1'b0), .HAS_CMP(1'b0)) i_data_regs_small (.*, .rd_data(rd_small),
    .pc_low(), .status(), .option(), .osc_cal(), .cmp_control(), .port_out(), .port_oe(), .irq());
  core_model i_core_model (.clk_sys, .rd_data, .rd_aux(rd_small), .addr, .wr_data, .wr_en, .rd_en);

  ////////////////////////////////////////
  // free-running 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // read both variants in one bus cycle
  task automatic rchk(input logic [5:0] a, input logic [7:0] e, input logic [7:0] es);
    logic [7:0] d, d2;
    i_core_model.rd(a, d, d2);
    chk(d, e);
    chk(d2, es);
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // a hang is cut well past the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge clk_sys);
    fail_count++;
    stop_test();
  end

  initial begin
    int i, k, v;
    rst = 1'b1;
    {other_rst, wake_cause, alu_flags_upd, alu_flags, hw_flag_load, hw_timeout} = '0;
    {hw_power_down, pc_load, pc_value, timer_tick, cmp_wake, dir_load, dir_value} = '0;
    {option_load, option_value, pins_in} = '0;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    rchk(6'h02, 8'hff, 8'hff);
    rchk(6'h03, 8'h18, 8'h18);
    rchk(6'h05, 8'hfe, 8'hfe);
    rchk(6'h07, 8'hff, 8'h00);
    chk(option, 8'hff);
    chk({4'h0, port_oe}, 8'h00);
    $display("reset values done");
    // general bytes: 08..0f exist only on the large file
    for (i = 8; i < 32; i++) begin
      m[i] = rnd() & 32'hff;
      i_core_model.wr(i[5:0], m[i][7:0]);
    end
    for (i = 8; i < 32; i++) begin
      rchk(i[5:0], m[i][7:0], i < 16 ? 8'h00 : m[i][7:0]);
    end
    $display("general bytes done");
    i_core_model.wr(6'h04, 8'h0c);
    i_core_model.wr(6'h00, 8'h5a);
    rchk(6'h0c, 8'h5a, 8'h00);
    i_core_model.wr(6'h04, 8'h13);
    rchk(6'h00, m[19][7:0], m[19][7:0]);
    rchk(6'h04, 8'hf3, 8'hf3);
    $display("indirect access done");
    // zeros on bits 4 and 3 of the data would show if those bits took the write
    i_core_model.wr(6'h03, 8'he7);
    rchk(6'h03, 8'hdf, 8'h9f);
    alu_flags <= 3'b010;
    alu_flags_upd <= 1'b1;
    i_core_model.wr(6'h03, 8'h00);
    alu_flags_upd <= 1'b0;
    rchk(6'h03, 8'h1a, 8'h1a);
    i_core_model.wr(6'h07, 8'h55);
    rchk(6'h07, 8'h55, 8'h00);
    // hardware-set flags and comparator wake; the small file must ignore the wake
    cmp_wake <= 1'b1;
    hw_power_down <= 1'b1;
    hw_flag_load <= 1'b1;
    @(posedge clk_sys);
    {cmp_wake, hw_flag_load} <= 2'h0;
    rchk(6'h03, 8'h4a, 8'h0a);
    rchk(6'h20, 8'h04, 8'h00);
    $display("status and comparator done");
    v = rnd();
    pc_value <= v[7:0];
    option_value <= v[15:8];
    dir_value <= v[19:16];
    pins_in <= v[23:20];
    {pc_load, option_load, dir_load} <= 3'h7;
    @(posedge clk_sys);
    {pc_load, option_load, dir_load} <= 3'h0;
    repeat (3) @(posedge clk_sys);
    chk(option, v[15:8]);
    chk({4'h0, port_oe}, {4'h0, ~v[19:16] & 4'h7});
    rchk(6'h02, v[7:0], v[7:0]);
    rchk(6'h06, {4'h0, v[23:20]}, {4'h0, v[23:20]});
    rchk(6'h20, {6'h0, |v[23:20], 1'b0}, {6'h0, |v[23:20], 1'b0});
    $display("loads and pins done");
    // timer wrap raises the interrupt only while unmasked; reading event status clears it
    for (k = 0; k < 2; k++) begin
      i_core_model.wr(6'h21, k == 0 ? 8'h01 : 8'h00);
      i_core_model.wr(6'h01, 8'hff);
      timer_tick <= 1'b1;
      @(posedge clk_sys);
      timer_tick <= 1'b0;
      repeat (2) @(posedge clk_sys);
      chk({7'h0, irq}, k == 0 ? 8'h01 : 8'h00);
      rchk(6'h20, 8'h01, 8'h01);
      @(posedge clk_sys);
      chk({7'h0, irq}, 8'h00);
    end
    $display("interrupt done");
    wake_cause <= 1'b1;
    other_rst <= 1'b1;
    @(posedge clk_sys);
    other_rst <= 1'b0;
    rchk(6'h03, 8'h8a, 8'h8a);
    rchk(6'h02, 8'hff, 8'hff);
    rchk(6'h1f, m[31][7:0], m[31][7:0]);
    rchk(6'h20, 8'h08, 8'h08);
    $display("wake reset done");
    stop_test();
  end
endmodule // data_regs_tb
